// [rtl/wdt_ctrl.sv]
// watchdog control and status register with counter, mode select and interrupt
// assumes cpu strobes, vector ack and reset cause flag are on clk_sys; the
// oscillator and fuse arrive as pins and are synchronised here
// Operation
// (RULE_01) timeout with interrupt configured sets the flag at bit 7
// (RULE_02) executing the watchdog vector clears the flag in hardware
// (RULE_03) writing one to the flag clears it, zero leaves it
// (RULE_04) request needs global enable, interrupt enable and flag all set
// (RULE_05) eight-bit register layout, all fields zero after reset except reset enable
// (RULE_06) mode from fuse, reset enable and interrupt enable; fuse forces reset mode
// (RULE_07) in combined mode vector clears enable and flag; next timeout resets
// (RULE_08) unlock needed to clear reset enable or change prescaler; self-clears after four
// (RULE_09) reset enable forced to one while watchdog reset flag is set
// (RULE_10) timeout comes from oscillator count, period chosen by four select bits
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module wdt_ctrl
  import wdt_ctrl_pkg::*;
#(
  parameter int CNT_W = 21
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire reg_req_t req,
  output logic [7:0] rdata,
  // cpu side
  input wire logic global_irq_enable,
  input wire logic vector_ack,
  input wire logic counter_restart,
  input wire logic watchdog_reset_flag,
  // pins
  input wire logic wdt_osc_pin,
  input wire logic always_on_fuse,
  // requests out
  output logic wdt_irq_req,
  output logic system_reset_req,
  output logic irq
);

  // prescaler period: 2048 ticks shifted by the select, clamped at the top
  function automatic logic [CNT_W-1:0] terminal(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > PS_MAX) ? PS_MAX : sel;
    terminal = CNT_W'((64'd1 << (PERIOD_BASE_LOG2 + int'(s))) - 64'd1);
  endfunction

  logic flag_r, ie_r, unlock_r, sre_r;
  logic [3:0] ps_r;
  logic [2:0] unlock_cnt_r;
  logic [CNT_W-1:0] cnt_r;
  logic osc_s1_r, osc_s2_r, osc_s3_r;
  logic fuse_s1_r, fuse_s2_r;
  logic [1:0] sts_r, mask_r;
  logic [7:0] rdata_r;
  logic wdt_irq_r, rst_req_r, irq_r;

  // pin synchronisers, first stage read only by the second
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
      fuse_s1_r <= 1'b0;
      fuse_s2_r <= 1'b0;
    end else begin
      osc_s1_r <= wdt_osc_pin;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      fuse_s1_r <= always_on_fuse;
      fuse_s2_r <= fuse_s1_r;
    end
  end

  // register decode
  wire wr_ctrl = req.wr && (req.addr == OFF_CTRL);
  wire wr_sts = req.wr && (req.addr == OFF_INT_STS);
  wire wr_mask = req.wr && (req.addr == OFF_INT_MASK);
  wire osc_tick = osc_s2_r && !osc_s3_r;

  // mode select; the fuse wins over both software bits
  wire wdt_mode_t mode = fuse_s2_r ? MODE_RESET :         // RULE_06
    wdt_mode_t'({sre_r, ie_r});

  // counter wraps at the selected period
  wire running = (mode != MODE_STOPPED);
  wire at_term = (cnt_r == terminal(ps_r));
  wire timeout = running && osc_tick && at_term;          // RULE_10
  wire [CNT_W-1:0] cnt_nxt = (!running || counter_restart || timeout) ? '0 :
    (osc_tick ? cnt_r + CNT_W'(1) : cnt_r);

  // timeout action by mode; combined mode resets only if the first went unserved
  wire to_irq = timeout && ((mode == MODE_IRQ) || (mode == MODE_BOTH && !flag_r));
  wire to_reset = timeout && ((mode == MODE_RESET) || (mode == MODE_BOTH && flag_r));

  // flag: set wins over both clears
  wire flag_clr = (wr_ctrl && req.wdata[BIT_FLAG]) || vector_ack;  // RULE_02 RULE_03
  wire flag_nxt = to_irq || (flag_r && !flag_clr);                 // RULE_01

  // vector in combined mode drops the enable, falling back to reset mode
  wire ie_vec_clr = vector_ack && sre_r && !fuse_s2_r;    // RULE_07
  wire ie_nxt = wr_ctrl ? req.wdata[BIT_IE] : (ie_r && !ie_vec_clr);

  // prescaler changes and reset enable clears only while unlocked
  wire [3:0] ps_wr = {req.wdata[BIT_PS3], req.wdata[BIT_PS_LO +: 3]};
  wire [3:0] ps_nxt = (wr_ctrl && unlock_r) ? ps_wr : ps_r;          // RULE_08
  wire sre_wr = !wr_ctrl ? sre_r :
    (req.wdata[BIT_SRE] ? 1'b1 : (unlock_r ? 1'b0 : sre_r));         // RULE_08
  wire sre_nxt = watchdog_reset_flag || sre_wr;                      // RULE_09

  // unlock window counts down four cycles, then clears itself
  wire unlock_set = wr_ctrl && req.wdata[BIT_UNLOCK];
  wire [2:0] ucnt_nxt = unlock_set ? UNLOCK_CYCLES :
    ((unlock_cnt_r != 3'h0) ? unlock_cnt_r - 3'h1 : 3'h0);
  wire unlock_nxt = unlock_set || (unlock_r && (unlock_cnt_r != 3'h1)); // RULE_08

  // interrupt status: sticky, write one clears, set wins
  wire [1:0] sts_set = {to_reset, to_irq};
  wire [1:0] sts_nxt = sts_set | (sts_r & ~(wr_sts ? req.wdata[1:0] : 2'h0));

  // read data, unmapped addresses answer zero
  wire [7:0] ctrl_view = {flag_r, ie_r, ps_r[3], unlock_r, sre_r, ps_r[2:0]}; // RULE_05
  wire [7:0] rd_mux = (req.addr == OFF_CTRL) ? ctrl_view :
    (req.addr == OFF_INT_STS) ? {6'h0, sts_r} :
    (req.addr == OFF_INT_MASK) ? {6'h0, mask_r} :
    (req.addr == OFF_COUNT) ? cnt_r[CNT_W-1 -: 8] : 8'h00;

  // control state
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flag_r <= CTRL_RST[BIT_FLAG];                       // RULE_05
      ie_r <= CTRL_RST[BIT_IE];
      unlock_r <= CTRL_RST[BIT_UNLOCK];
      sre_r <= SRE_RST;
      ps_r <= 4'h0;
      unlock_cnt_r <= 3'h0;
      cnt_r <= '0;
    end else begin
      flag_r <= flag_nxt;
      ie_r <= ie_nxt;
      unlock_r <= unlock_nxt;
      sre_r <= sre_nxt;
      ps_r <= ps_nxt;
      unlock_cnt_r <= ucnt_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // status, outputs and read port; outputs lag state by one cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sts_r <= STS_RST;
      mask_r <= MASK_RST;
      rdata_r <= 8'h00;
      wdt_irq_r <= 1'b0;
      rst_req_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      mask_r <= wr_mask ? req.wdata[1:0] : mask_r;
      rdata_r <= req.rd ? rd_mux : 8'h00;
      wdt_irq_r <= global_irq_enable && ie_r && flag_r; // RULE_04
      rst_req_r <= to_reset;
      irq_r <= |(sts_r & mask_r);
    end
  end

  assign rdata = rdata_r;
  assign wdt_irq_req = wdt_irq_r;
  assign system_reset_req = rst_req_r;
  assign irq = irq_r;

  // ---- assertions ----
  sequence s_unlock_write;
    unlock_set && !$past(unlock_set);
  endsequence

  // a rewrite inside the window restarts it, so only the minimum is held here
  sequence s_unlock_held;
    unlock_r [*4];
  endsequence

  a_flag_on_timeout: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_01
    to_irq |=> flag_r)
    else $error("flag not set after interrupt timeout");

  a_vector_clears_flag: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_02
    (vector_ack && !to_irq) |=> !flag_r)
    else $error("vector did not clear flag");

  a_w1c_flag: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_03
    (wr_ctrl && !req.wdata[BIT_FLAG] && !vector_ack && flag_r) |=> flag_r)
    else $error("writing zero changed the flag");

  a_irq_gating: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_04
    wdt_irq_req |-> $past(global_irq_enable) && $past(ie_r) && $past(flag_r))
    else $error("interrupt request without all three enables");

  a_read_layout: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_05
    (req.rd && req.addr == OFF_CTRL) |=> rdata[BIT_FLAG] == $past(flag_r)
      && rdata[BIT_SRE] == $past(sre_r))
    else $error("control read data out of layout");

  a_fuse_reset_mode: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_06
    (timeout && fuse_s2_r) |=> system_reset_req && !$past(to_irq))
    else $error("fuse did not force reset on timeout");

  a_both_vector: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_07
    (vector_ack && mode == MODE_BOTH && !wr_ctrl) |=> !ie_r)
    else $error("vector left interrupt enable set in combined mode");

  a_unlock_four: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_08
    (s_unlock_write ##1 !unlock_set [*4]) |=> !unlock_r)
    else $error("unlock window not four cycles");

  a_unlock_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_08
    unlock_set |=> s_unlock_held)
    else $error("unlock window length wrong");

  a_sre_forced: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_09
    watchdog_reset_flag |=> sre_r)
    else $error("reset enable not forced by reset flag");

  a_timeout_period: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_10
    timeout |-> cnt_r == terminal(ps_r) ##1 cnt_r == '0)
    else $error("timeout off the selected period");

endmodule

`default_nettype wire

// [pkg/wdt_ctrl_pkg.sv]
// constants, types and bus carrier for the watchdog control and status logic
// assumes one 100 MHz system clock and a plain register port from the cpu side
package wdt_ctrl_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] OFF_CTRL = 4'h0; // watchdog_control_status
  localparam logic [3:0] OFF_INT_STS = 4'h1;
  localparam logic [3:0] OFF_INT_MASK = 4'h2;
  localparam logic [3:0] OFF_COUNT = 4'h3;

  // field positions of watchdog_control_status
  localparam int BIT_FLAG = 7;
  localparam int BIT_IE = 6;
  localparam int BIT_PS3 = 5;
  localparam int BIT_UNLOCK = 4;
  localparam int BIT_SRE = 3;
  localparam int BIT_PS_LO = 0;

  // interrupt status bit positions
  localparam int STS_TIMEOUT = 0;
  localparam int STS_RESET = 1;

  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic SRE_RST = 1'b0; // undetermined in hardware; zero chosen
  localparam logic [1:0] STS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // cycle counts
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam int PERIOD_BASE_LOG2 = 11; // shortest period 2048 oscillator ticks
  localparam logic [3:0] PS_MAX = 4'h9; // higher selects fall back to this one

  // mode selected by fuse, reset enable and interrupt enable
  typedef enum logic [1:0] {
    MODE_STOPPED = 2'b00,
    MODE_IRQ = 2'b01,
    MODE_BOTH = 2'b11,
    MODE_RESET = 2'b10
  } wdt_mode_t;

  // one register request from the cpu
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// [tb/wdt_ctrl_tb.sv]
// self-checking bench for the watchdog control and status register block
// assumes the design module wdt_ctrl and its package; bench drives every port
`timescale 1ns/10ps
`default_nettype none
module watchdog_control_status_logic_tb;
  import wdt_ctrl_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  reg_req_t req = '0;
  logic gie = 1'b1;
  logic ack = 1'b0;
  logic kick = 1'b0;
  logic wrf = 1'b0;
  logic osc = 1'b0;
  logic fuse = 1'b0;
  logic [7:0] rdata;
  logic [7:0] d;
  logic wdt_irq_req;
  logic system_reset_req;
  logic irq;
  int n_errors = 0;
  int compares = 0;
  int n_rst = 0;
  int rst_base = 0;
  int n;
  // clock and a count of reset pulses, which last one cycle only
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (system_reset_req === 1'b1) n_rst <= n_rst + 1;
  wdt_ctrl wdt_ctrl_inst (.clk_sys(clk_sys), .resetn(resetn), .req(req), .rdata(rdata),
    .global_irq_enable(gie), .vector_ack(ack), .counter_restart(kick),
    .watchdog_reset_flag(wrf), .wdt_osc_pin(osc), .always_on_fuse(fuse),
    .wdt_irq_req(wdt_irq_req), .system_reset_req(system_reset_req), .irq(irq));
  // verdict and end of run
  task automatic close_out;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bus cycles; read data stand only in the cycle after the strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse_ack;
    @(posedge clk_sys);
    ack <= 1'b1;
    @(posedge clk_sys);
    ack <= 1'b0;
  endtask
  // five system cycles per oscillator tick; two high covers the synchroniser
  task automatic tick_n(input int k);
    repeat (k) begin
      @(posedge clk_sys);
      osc <= 1'b1;
      repeat (2) @(posedge clk_sys);
      osc <= 1'b0;
      cyc(2);
    end
  endtask
  // ticks until the chosen output shows up; reset pulses counted from entry
  task automatic tick_until(input int sel);
    n = 0;
    rst_base = n_rst;
    while (!((sel == 0 && wdt_irq_req === 1'b1) || (sel == 1 && irq === 1'b1)
        || (sel == 2 && n_rst > rst_base))) begin
      if (n == 2200) begin
        n_errors++;
        close_out();
      end
      tick_n(1);
      n++;
    end
  endtask
  // reset value, unmapped place and the timed unlock window
  task automatic t_regs;
    rd(OFF_CTRL);
    chk("ctrl_rst", CTRL_RST, d);
    rd(4'h5);
    chk("unmapped", 8'h00, d);
    wr(OFF_CTRL, 8'h07);
    rd(OFF_CTRL);
    chk("ps_locked", 8'h00, d);
    wr(OFF_CTRL, 8'h10);
    rd(OFF_CTRL);
    chk("unlock_set", 8'h10, d);
    cyc(4);
    rd(OFF_CTRL);
    chk("unlock_gone", 8'h00, d);
    wr(OFF_CTRL, 8'h10);
    wr(OFF_CTRL, 8'h27);
    cyc(5);
    rd(OFF_CTRL);
    chk("ps_open", 8'h27, d);
    wr(OFF_CTRL, 8'h10);
    wr(OFF_CTRL, 8'h00);
    cyc(5);
  endtask
  // interrupt mode: period, flag clearing, masking and global enable
  task automatic t_irq;
    wr(OFF_INT_MASK, 8'h03);
    wr(OFF_CTRL, 8'h40);
    tick_until(0);
    chk("ticks", 8'h01, 8'(n >= 2048 && n <= 2051));
    chk("irq_on", 8'h01, {7'h00, irq});
    rd(OFF_CTRL);
    chk("flag_set", 8'hc0, d);
    wr(OFF_CTRL, 8'h40);
    rd(OFF_CTRL);
    chk("flag_w0", 8'hc0, d);
    wr(OFF_CTRL, 8'hc0);
    rd(OFF_CTRL);
    chk("flag_w1c", 8'h40, d);
    cyc(2);
    chk("req_off", 8'h00, {7'h00, wdt_irq_req});
    wr(OFF_INT_MASK, 8'h00);
    cyc(2);
    chk("irq_masked", 8'h00, {7'h00, irq});
    wr(OFF_INT_MASK, 8'h03);
    wr(OFF_INT_STS, 8'h01);
    cyc(2);
    chk("irq_clr", 8'h00, {7'h00, irq});
    @(posedge clk_sys);
    gie <= 1'b0;
    tick_until(1);
    chk("gie_off", 8'h00, {7'h00, wdt_irq_req});
    @(posedge clk_sys);
    gie <= 1'b1;
    cyc(2);
    chk("gie_on", 8'h01, {7'h00, wdt_irq_req});
    pulse_ack();
    rd(OFF_CTRL);
    chk("vector_clr", 8'h40, d);
    wr(OFF_INT_STS, 8'h01);
  endtask
  // combined mode falls back to reset mode once the vector runs
  task automatic t_both;
    wr(OFF_CTRL, 8'h48);
    tick_until(0);
    chk("no_reset_yet", 8'h00, 8'(n_rst));
    tick_until(2);
    chk("unserved_reset", 8'h01, 8'(n_rst));
    rd(OFF_INT_STS);
    chk("sts_both", 8'h03, d);
    wr(OFF_INT_STS, 8'h03);
    rd(OFF_INT_STS);
    chk("sts_w1c", 8'h00, d);
    pulse_ack();
    rd(OFF_CTRL);
    chk("both_vector", 8'h08, d);
    tick_until(2);
    chk("reset_fallback", 8'h02, 8'(n_rst));
  endtask
  // fuse forces reset mode over the interrupt enable; a restart zeroes the count
  task automatic t_fuse;
    @(posedge clk_sys);
    fuse <= 1'b1;
    cyc(3);
    wr(OFF_CTRL, 8'h40);
    tick_n(1000);
    @(posedge clk_sys);
    kick <= 1'b1;
    @(posedge clk_sys);
    kick <= 1'b0;
    tick_until(2);
    chk("kick_restart", 8'h01, 8'(n >= 2048 && n <= 2051));
    rd(OFF_CTRL);
    chk("fuse_no_flag", 8'h40, d);
    chk("fuse_no_req", 8'h00, {7'h00, wdt_irq_req});
  endtask
  // reset cause flag holds reset enable up even with unlock open
  task automatic t_rflag;
    @(posedge clk_sys);
    wrf <= 1'b1;
    wr(OFF_CTRL, 8'h10);
    wr(OFF_CTRL, 8'h00);
    rd(OFF_CTRL);
    chk("sre_forced", 8'h08, d & 8'h08);
    @(posedge clk_sys);
    wrf <= 1'b0;
    wr(OFF_CTRL, 8'h10);
    wr(OFF_CTRL, 8'h00);
    cyc(5);
    rd(OFF_CTRL);
    chk("sre_cleared", 8'h00, d);
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs();
    t_irq();
    t_both();
    t_rflag();
    t_fuse();
    close_out();
  end
endmodule
`default_nettype wire
